// file: verilog/mcuid_pkg.sv
// Constants and types shared by the instruction decoder and its sequencer.
// How it works
// - Instruction words are 14 bits: an opcode plus operand fields.
// - Every word falls in byte, bit, or literal and control class.
// - Destination bit zero targets the accumulator, one the file register.
// - The file address field is seven bits, zero to 127.
// - Bit operations select one of eight bits of the file register.
// - Literal operand is eight bits for data, eleven for jump targets.
// - Don't-care bits are ignored; either value decodes the same way.
// - One cycle each, two when a skip is true or the counter changes.
// - Each instruction cycle spans exactly four oscillator periods.
// - Self-modifying port operations read the pins, not the latch.
// - Writing the timer zero count clears an assigned shared prescaler.
package mcuid_pkg;

  // ---------------------------------------------------------------------
  // Widths and field positions
  // ---------------------------------------------------------------------
  localparam int WORD_W = 14;
  localparam int FILE_W = 7;
  localparam int BIT_W = 3;
  localparam int LIT8_W = 8;
  localparam int LIT11_W = 11;
  localparam int DEST_POS = 7;
  localparam int BIT_LSB = 7;
  localparam int PHASE_W = 2;
  localparam logic [1:0] LAST_PHASE = 2'h3;
  localparam logic [1:0] RST_PHASE = 2'h0;

  // ---------------------------------------------------------------------
  // Special file addresses and flag reset values
  // ---------------------------------------------------------------------
  localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;
  localparam logic [6:0] PORT_A_ADDR = 7'h05;
  localparam logic [6:0] PORT_C_ADDR = 7'h07;
  localparam logic WDOG_FLAG_RST = 1'h1;
  localparam logic SLEEP_FLAG_RST = 1'h1;

  // ---------------------------------------------------------------------
  // Instruction classes and operations
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    CLS_BYTE, CLS_BIT, CLS_LIT
  } mcuid_class_t;

  typedef enum logic [5:0] {
    OP_NO_OPERATION, OP_MOVWF, OP_CLRW, OP_CLRF, OP_SUBWF, OP_DECF, OP_IORWF,
    OP_ANDWF, OP_XORWF, OP_ADDWF, OP_MOVF, OP_COMF, OP_INCF, OP_DECFSZ,
    OP_RRF, OP_RLF, OP_SWAPF, OP_INCFSZ, OP_BCF, OP_BSF, OP_BTFSC,
    OP_BTFSS, OP_CALL, OP_GOTO, OP_MOVLW, OP_RETLW, OP_IORLW, OP_ANDLW,
    OP_XORLW, OP_SUBLW, OP_ADDLW, OP_RETURN, OP_RETFIE, OP_CLRWDT,
    OP_SLEEP, OP_ILLEGAL
  } mcuid_op_t;

  typedef enum {ST_RUN, ST_FLUSH} mcuid_state_t;

endpackage : mcuid_pkg

// file: verilog/mcuid_phase.sv
// Four-phase instruction cycle counter.
`timescale 1ns/10ps
module mcuid_phase (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Phase outputs
  output logic [1:0] phase_o,
  output logic cycle_end_o
);

  logic [1:0] phase_ff;

  // -----------------------------------------------------------------------
  // Phase counter
  // -----------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_ff <= mcuid_pkg::RST_PHASE;
    end else begin
      phase_ff <= phase_ff + 2'h1;
    end
  end

  assign phase_o = phase_ff;
  assign cycle_end_o = (phase_ff == mcuid_pkg::LAST_PHASE);

  property p_four;
    @(posedge mclk_i) disable iff (!rst_n_i)
      cycle_end_o |=> !cycle_end_o [*3] ##1 cycle_end_o;
  endproperty
  a_four: assert property (p_four)
    else $error("Instruction cycle is not four clocks.");

endmodule : mcuid_phase

// file: verilog/mcuid_decoder.sv
// Instruction decoder and cycle sequencer of the core.
`timescale 1ns/10ps
module mcuid_decoder (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Instruction word and execution status
  input wire logic [13:0] instr_i,
  input wire logic skip_true_i,
  input wire logic prescaler_on_timer_i,
  input wire logic wdog_expired_i,
  // Decoded fields
  output logic [1:0] class_o,
  output logic [5:0] op_o,
  output logic [6:0] file_addr_o,
  output logic [2:0] bit_sel_o,
  output logic [10:0] literal_o,
  output logic dest_file_o,
  output logic dest_acc_o,
  // Timing and side effects
  output logic cycle_end_o,
  output logic flush_o,
  output logic read_pins_o,
  output logic prescaler_clr_o,
  output logic watchdog_expiry_flag_o,
  output logic sleep_entered_flag_o
);

  // -----------------------------------------------------------------------
  // Decode function
  // -----------------------------------------------------------------------
  function automatic mcuid_pkg::mcuid_op_t decode(input logic [13:0] w);
    mcuid_pkg::mcuid_op_t op;
    op = mcuid_pkg::OP_ILLEGAL;
    unique case (w[13:12])
      2'h0: begin
        unique case (w[11:8])
          4'h0: begin
            if (w[7]) op = mcuid_pkg::OP_MOVWF;
            else if (w[6:0] == 7'h64) op = mcuid_pkg::OP_CLRWDT;
            else if (w[6:0] == 7'h63) op = mcuid_pkg::OP_SLEEP;
            else if (w[6:0] == 7'h08) op = mcuid_pkg::OP_RETURN;
            else if (w[6:0] == 7'h09) op = mcuid_pkg::OP_RETFIE;
            else if (w[4:0] == 5'h00) begin
              op = mcuid_pkg::OP_NO_OPERATION;
            end
          end
          4'h1: op = w[7] ? mcuid_pkg::OP_CLRF : mcuid_pkg::OP_CLRW;
          4'h2: op = mcuid_pkg::OP_SUBWF;
          4'h3: op = mcuid_pkg::OP_DECF;
          4'h4: op = mcuid_pkg::OP_IORWF;
          4'h5: op = mcuid_pkg::OP_ANDWF;
          4'h6: op = mcuid_pkg::OP_XORWF;
          4'h7: op = mcuid_pkg::OP_ADDWF;
          4'h8: op = mcuid_pkg::OP_MOVF;
          4'h9: op = mcuid_pkg::OP_COMF;
          4'hA: op = mcuid_pkg::OP_INCF;
          4'hB: op = mcuid_pkg::OP_DECFSZ;
          4'hC: op = mcuid_pkg::OP_RRF;
          4'hD: op = mcuid_pkg::OP_RLF;
          4'hE: op = mcuid_pkg::OP_SWAPF;
          4'hF: op = mcuid_pkg::OP_INCFSZ;
        endcase
      end
      2'h1: begin
        unique case (w[11:10])
          2'h0: op = mcuid_pkg::OP_BCF;
          2'h1: op = mcuid_pkg::OP_BSF;
          2'h2: op = mcuid_pkg::OP_BTFSC;
          2'h3: op = mcuid_pkg::OP_BTFSS;
        endcase
      end
      2'h2: op = w[11] ? mcuid_pkg::OP_GOTO : mcuid_pkg::OP_CALL;
      2'h3: begin
        // Don't-care bits are left out of each match below.
        if (w[11:10] == 2'h0) op = mcuid_pkg::OP_MOVLW;
        else if (w[11:10] == 2'h1) op = mcuid_pkg::OP_RETLW;
        else if (w[11:8] == 4'h8) op = mcuid_pkg::OP_IORLW;
        else if (w[11:8] == 4'h9) op = mcuid_pkg::OP_ANDLW;
        else if (w[11:8] == 4'hA) op = mcuid_pkg::OP_XORLW;
        else if (w[11:9] == 3'h6) op = mcuid_pkg::OP_SUBLW;
        else if (w[11:9] == 3'h7) op = mcuid_pkg::OP_ADDLW;
      end
    endcase
    return op;
  endfunction : decode

  function automatic logic is_skip(input mcuid_pkg::mcuid_op_t op);
    return op inside {mcuid_pkg::OP_DECFSZ, mcuid_pkg::OP_INCFSZ,
      mcuid_pkg::OP_BTFSC, mcuid_pkg::OP_BTFSS};
  endfunction : is_skip

  function automatic logic is_branch(input mcuid_pkg::mcuid_op_t op);
    return op inside {mcuid_pkg::OP_CALL, mcuid_pkg::OP_GOTO,
      mcuid_pkg::OP_RETURN, mcuid_pkg::OP_RETFIE, mcuid_pkg::OP_RETLW};
  endfunction : is_branch

  // -----------------------------------------------------------------------
  // Combinational decode of the current word
  // -----------------------------------------------------------------------
  mcuid_pkg::mcuid_op_t nxt_op;
  mcuid_pkg::mcuid_class_t nxt_class;
  logic nxt_dest_file;
  logic nxt_writes_file;
  logic nxt_self_mod;
  logic nxt_taken;
  logic [1:0] phase;
  logic cyc_end;

  mcuid_phase u_phase (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .phase_o(phase),
    .cycle_end_o(cyc_end)
  );

  always_comb begin
    nxt_op = decode(instr_i);
    unique case (instr_i[13:12])
      2'h0: nxt_class = mcuid_pkg::CLS_BYTE;
      2'h1: nxt_class = mcuid_pkg::CLS_BIT;
      default: nxt_class = mcuid_pkg::CLS_LIT;
    endcase
    nxt_dest_file = 1'b0;
    if (nxt_op inside {mcuid_pkg::OP_MOVWF, mcuid_pkg::OP_CLRF}) begin
      nxt_dest_file = 1'b1;
    end else if (nxt_class == mcuid_pkg::CLS_BYTE &&
                 instr_i[11:8] > 4'h1) begin
      nxt_dest_file = instr_i[mcuid_pkg::DEST_POS];
    end
    nxt_writes_file = nxt_dest_file ||
      nxt_op inside {mcuid_pkg::OP_BCF, mcuid_pkg::OP_BSF};
    nxt_self_mod = nxt_writes_file && !(nxt_op inside
      {mcuid_pkg::OP_MOVWF, mcuid_pkg::OP_CLRF});
    nxt_taken = is_branch(nxt_op) || (is_skip(nxt_op) && skip_true_i);
  end

  // -----------------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------------
  mcuid_pkg::mcuid_state_t state_ff;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= mcuid_pkg::ST_RUN;
    end else if (cyc_end) begin
      unique case (state_ff)
        mcuid_pkg::ST_RUN: begin
          if (nxt_taken) state_ff <= mcuid_pkg::ST_FLUSH;
        end
        mcuid_pkg::ST_FLUSH: state_ff <= mcuid_pkg::ST_RUN;
      endcase
    end
  end

  logic flushing;
  assign flushing = (state_ff == mcuid_pkg::ST_FLUSH);

  // -----------------------------------------------------------------------
  // Registered decode outputs
  // -----------------------------------------------------------------------
  logic [1:0] class_ff;
  logic [5:0] op_ff;
  logic [6:0] file_ff;
  logic [2:0] bit_ff;
  logic [10:0] lit_ff;
  logic dest_file_ff;
  logic dest_acc_ff;
  logic cycle_end_ff;
  logic flush_ff;
  logic pins_ff;
  logic pscl_ff;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      class_ff <= 2'h0;
      op_ff <= 6'h00;
      file_ff <= 7'h00;
      bit_ff <= 3'h0;
      lit_ff <= 11'h000;
      dest_file_ff <= 1'b0;
      dest_acc_ff <= 1'b0;
      pins_ff <= 1'b0;
      pscl_ff <= 1'b0;
    end else if (flushing) begin
      op_ff <= 6'(mcuid_pkg::OP_NO_OPERATION);
      class_ff <= 2'(mcuid_pkg::CLS_BYTE);
      dest_file_ff <= 1'b0;
      dest_acc_ff <= 1'b0;
      pins_ff <= 1'b0;
      pscl_ff <= 1'b0;
    end else begin
      class_ff <= 2'(nxt_class);
      op_ff <= 6'(nxt_op);
      file_ff <= instr_i[6:0];
      bit_ff <= instr_i[9:7];
      lit_ff <= (instr_i[13:11] == 3'h4 || instr_i[13:11] == 3'h5) ?
        instr_i[10:0] : {3'h0, instr_i[7:0]};
      dest_file_ff <= nxt_writes_file;
      dest_acc_ff <= !nxt_writes_file && nxt_class == mcuid_pkg::CLS_BYTE &&
        !(nxt_op inside {mcuid_pkg::OP_NO_OPERATION, mcuid_pkg::OP_CLRWDT,
        mcuid_pkg::OP_SLEEP, mcuid_pkg::OP_RETURN, mcuid_pkg::OP_RETFIE});
      pins_ff <= nxt_self_mod && instr_i[6:0] >= mcuid_pkg::PORT_A_ADDR &&
        instr_i[6:0] <= mcuid_pkg::PORT_C_ADDR;
      pscl_ff <= nxt_writes_file && prescaler_on_timer_i &&
        instr_i[6:0] == mcuid_pkg::TIMER_ZERO_ADDR;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cycle_end_ff <= 1'b0;
      flush_ff <= 1'b0;
    end else begin
      cycle_end_ff <= cyc_end;
      flush_ff <= flushing;
    end
  end

  // -----------------------------------------------------------------------
  // Time-out and power-down flags
  // -----------------------------------------------------------------------
  logic wdog_meta_ff;
  logic wdog_sync_ff;
  logic wdog_flag_ff;
  logic sleep_flag_ff;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wdog_meta_ff <= 1'b0;
      wdog_sync_ff <= 1'b0;
    end else begin
      wdog_meta_ff <= wdog_expired_i;
      wdog_sync_ff <= wdog_meta_ff;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wdog_flag_ff <= mcuid_pkg::WDOG_FLAG_RST;
      sleep_flag_ff <= mcuid_pkg::SLEEP_FLAG_RST;
    end else begin
      if (wdog_sync_ff) begin
        wdog_flag_ff <= 1'b0;
      end else if (cyc_end && !flushing && (nxt_op == mcuid_pkg::OP_CLRWDT
                   || nxt_op == mcuid_pkg::OP_SLEEP)) begin
        wdog_flag_ff <= 1'b1;
      end
      if (cyc_end && !flushing) begin
        if (nxt_op == mcuid_pkg::OP_CLRWDT) sleep_flag_ff <= 1'b1;
        if (nxt_op == mcuid_pkg::OP_SLEEP) sleep_flag_ff <= 1'b0;
      end
    end
  end

  assign class_o = class_ff;
  assign op_o = op_ff;
  assign file_addr_o = file_ff;
  assign bit_sel_o = bit_ff;
  assign literal_o = lit_ff;
  assign dest_file_o = dest_file_ff;
  assign dest_acc_o = dest_acc_ff;
  assign cycle_end_o = cycle_end_ff;
  assign flush_o = flush_ff;
  assign read_pins_o = pins_ff;
  assign prescaler_clr_o = pscl_ff;
  assign watchdog_expiry_flag_o = wdog_flag_ff;
  assign sleep_entered_flag_o = sleep_flag_ff;

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  property p_goto_flush;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (cyc_end && !flushing && instr_i[13:11] == 3'h5) |=> flushing [*4];
  endproperty
  a_goto_flush: assert property (p_goto_flush)
    else $error("Jump did not flush one cycle.");

  property p_flush_nop;
    @(posedge mclk_i) disable iff (!rst_n_i)
      flushing |=> op_ff == 6'(mcuid_pkg::OP_NO_OPERATION) && !dest_file_ff;
  endproperty
  a_flush_nop: assert property (p_flush_nop)
    else $error("Discarded word was not a no-operation.");

  property p_dest;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (!flushing && instr_i[13:11] == 3'h1) |=>
        dest_file_o == $past(instr_i[7]) && dest_acc_o == !$past(instr_i[7]);
  endproperty
  a_dest: assert property (p_dest)
    else $error("Destination select misrouted.");

  property p_file;
    @(posedge mclk_i) disable iff (!rst_n_i)
      !flushing |=> file_addr_o == $past(instr_i[6:0]);
  endproperty
  a_file: assert property (p_file)
    else $error("File address field wrong.");

  property p_bit;
    @(posedge mclk_i) disable iff (!rst_n_i)
      !flushing |=> bit_sel_o == $past(instr_i[9:7]);
  endproperty
  a_bit: assert property (p_bit)
    else $error("Bit select field wrong.");

  property p_lit;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (!flushing && instr_i[13:12] == 2'h3) |=> literal_o[10:8] == 3'h0;
  endproperty
  a_lit: assert property (p_lit)
    else $error("Data literal wider than eight bits.");

  property p_dontcare;
    @(posedge mclk_i) disable iff (!rst_n_i)
      decode({instr_i[13:9], 1'b0, instr_i[7:0]}) ==
      decode({instr_i[13:9], 1'b1, instr_i[7:0]}) ||
      instr_i[13:10] != 4'hF;
  endproperty
  a_dontcare: assert property (p_dontcare)
    else $error("Don't-care bit changed the decode.");

  property p_sleep;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (cyc_end && !flushing && instr_i == 14'h0063 && !wdog_sync_ff) |=>
        !sleep_flag_ff && wdog_flag_ff;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("Sleep did not update status flags.");

  property p_pscl;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (!flushing && instr_i == 14'h0081 && prescaler_on_timer_i) |=>
        prescaler_clr_o;
  endproperty
  a_pscl: assert property (p_pscl)
    else $error("Timer write left prescaler intact.");

  c_flush: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    flushing && cyc_end);
  c_skip: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    cyc_end && is_skip(nxt_op) && skip_true_i);
  c_pins: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    read_pins_o);

endmodule : mcuid_decoder

// file: sim/mcu_instruction_decoder_bench.sv
// Self-checking testbench of the instruction decoder and sequencer.
`timescale 1ns/10ps
module mcu_instruction_decoder_bench;
  // ---------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------
  logic mclk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [13:0] instr_i = 14'h0000;
  logic skip_true_i = 1'h0;
  logic prescaler_on_timer_i = 1'h0;
  logic wdog_expired_i = 1'h0;
  logic [1:0] class_o;
  logic [5:0] op_o;
  logic [6:0] file_addr_o;
  logic [2:0] bit_sel_o;
  logic [10:0] literal_o;
  logic dest_file_o;
  logic dest_acc_o;
  logic cycle_end_o;
  logic flush_o;
  logic read_pins_o;
  logic prescaler_clr_o;
  logic watchdog_expiry_flag_o;
  logic sleep_entered_flag_o;
  int mismatches = 0;
  int checks = 0;
  int flush_cnt = 0;
  int gap = 0;
  integer seed = 45520;
  logic [13:0] fw [10] = '{14'h2ABC, 14'h2123, 14'h0008, 14'h0009,
    14'h3455, 14'h0B85, 14'h0B85, 14'h0F20, 14'h1820, 14'h1C20};
  logic fs [10] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1,
    1'h0};
  int fn [10] = '{4, 4, 4, 4, 4, 4, 0, 4, 4, 0};
  logic [13:0] dc [10] = '{14'h0000, 14'h0020, 14'h0040, 14'h0060,
    14'h0100, 14'h017F, 14'h3E05, 14'h3F05, 14'h3C00, 14'h3300};

  mcuid_decoder uut (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .instr_i(instr_i),
    .skip_true_i(skip_true_i),
    .prescaler_on_timer_i(prescaler_on_timer_i),
    .wdog_expired_i(wdog_expired_i),
    .class_o(class_o),
    .op_o(op_o),
    .file_addr_o(file_addr_o),
    .bit_sel_o(bit_sel_o),
    .literal_o(literal_o),
    .dest_file_o(dest_file_o),
    .dest_acc_o(dest_acc_o),
    .cycle_end_o(cycle_end_o),
    .flush_o(flush_o),
    .read_pins_o(read_pins_o),
    .prescaler_clr_o(prescaler_clr_o),
    .watchdog_expiry_flag_o(watchdog_expiry_flag_o),
    .sleep_entered_flag_o(sleep_entered_flag_o)
  );

  // ---------------------------------------------------------------------
  // Expected decode
  // ---------------------------------------------------------------------
  // Byte and bit groups follow the declaration order of the operation type.
  function automatic mcuid_pkg::mcuid_op_t exp_op(input logic [13:0] w);
    if (w[13:8] == 6'h00) begin
      if (w[7]) return mcuid_pkg::OP_MOVWF;
      if (w[4:0] == 5'h00) return mcuid_pkg::OP_NO_OPERATION;
      if (w[6:0] == 7'h08) return mcuid_pkg::OP_RETURN;
      if (w[6:0] == 7'h09) return mcuid_pkg::OP_RETFIE;
      if (w[6:0] == 7'h64) return mcuid_pkg::OP_CLRWDT;
      if (w[6:0] == 7'h63) return mcuid_pkg::OP_SLEEP;
      return mcuid_pkg::OP_ILLEGAL;
    end
    if (w[13:8] == 6'h01) begin
      return w[7] ? mcuid_pkg::OP_CLRF : mcuid_pkg::OP_CLRW;
    end
    if (w[13:12] == 2'h0) return mcuid_pkg::mcuid_op_t'(6'(w[11:8]) + 6'h02);
    if (w[13:12] == 2'h1) return mcuid_pkg::mcuid_op_t'(6'(w[11:10]) + 6'h12);
    if (w[13:12] == 2'h2) begin
      return w[11] ? mcuid_pkg::OP_GOTO : mcuid_pkg::OP_CALL;
    end
    if (w[11:10] == 2'h0) return mcuid_pkg::OP_MOVLW;
    if (w[11:10] == 2'h1) return mcuid_pkg::OP_RETLW;
    if (w[11:9] == 3'h6) return mcuid_pkg::OP_SUBLW;
    if (w[11:9] == 3'h7) return mcuid_pkg::OP_ADDLW;
    if (w[9:8] == 2'h0) return mcuid_pkg::OP_IORLW;
    if (w[9:8] == 2'h1) return mcuid_pkg::OP_ANDLW;
    if (w[9:8] == 2'h2) return mcuid_pkg::OP_XORLW;
    return mcuid_pkg::OP_ILLEGAL;
  endfunction : exp_op

  // ---------------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen,
      input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task automatic chk_word(input logic [13:0] w, input logic p);
    mcuid_pkg::mcuid_op_t op;
    logic dop;
    logic wf;
    op = exp_op(w);
    dop = (w[13:12] == 2'h0) && (w[11:9] != 3'h0);
    wf = (w[13:9] == 5'h00 && w[7]) || (dop && w[7]) || w[13:11] == 3'h2;
    if (flush_o !== 1'h0) return;
    check("op", op_o, op);
    check("file", file_addr_o, w[6:0]);
    check("bit", bit_sel_o, w[9:7]);
    if (!(op inside {mcuid_pkg::OP_RETURN, mcuid_pkg::OP_RETFIE,
        mcuid_pkg::OP_CLRWDT, mcuid_pkg::OP_SLEEP,
        mcuid_pkg::OP_ILLEGAL})) begin
      check("class", class_o, w[13] ? mcuid_pkg::CLS_LIT :
        (w[12] ? mcuid_pkg::CLS_BIT : mcuid_pkg::CLS_BYTE));
    end
    if (w[13]) begin
      check("lit", literal_o, (w[12] == 1'h0) ? w[10:0] :
        {3'h0, w[7:0]});
    end
    if (w[13:11] == 3'h2) check("bitdst", dest_file_o, 1'h1);
    if (dop) begin
      check("dfile", dest_file_o, w[7]);
      check("dacc", dest_acc_o, !w[7]);
      if (w[7]) begin
        check("pins", read_pins_o, w[6:0] >= mcuid_pkg::PORT_A_ADDR &&
          w[6:0] <= mcuid_pkg::PORT_C_ADDR);
      end
    end
    check("pscl", prescaler_clr_o,
      wf && w[6:0] == mcuid_pkg::TIMER_ZERO_ADDR && p);
  endtask : chk_word

  // Presents one word for a whole four-clock instruction cycle.
  task automatic run(input logic [13:0] w, input logic s, input logic p);
    @(negedge mclk_i);
    instr_i = w;
    skip_true_i = s;
    prescaler_on_timer_i = p;
    repeat (2) @(negedge mclk_i);
    chk_word(w, p);
    @(negedge mclk_i);
  endtask : run

  // ---------------------------------------------------------------------
  // Monitors
  // ---------------------------------------------------------------------
  always @(negedge mclk_i) begin
    if (rst_n_i && flush_o === 1'h1) begin
      flush_cnt++;
      check("flushop", op_o, mcuid_pkg::OP_NO_OPERATION);
    end
  end

  always @(negedge mclk_i) begin
    if (!rst_n_i) begin
      gap = 0;
    end else begin
      gap++;
      if (cycle_end_o === 1'h1) begin
        check("cycle", gap, 4);
        gap = 0;
      end
    end
  end

  initial begin
    forever #50 mclk_i = ~mclk_i;
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    mismatches++;
    finish_test();
  end

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (6) @(negedge mclk_i);
    check("rto", watchdog_expiry_flag_o, 1'h1);
    check("rpd", sleep_entered_flag_o, 1'h1);
    check("rend", cycle_end_o, 1'h0);
    rst_n_i <= 1'h1;
    for (int i = 0; i < 10; i++) begin
      run(dc[i], 1'h0, 1'h0);
    end
    for (int i = 0; i < 10; i++) begin
      flush_cnt = 0;
      run(fw[i], fs[i], 1'h0);
      run(14'h0000, 1'h0, 1'h0);
      run(14'h0000, 1'h0, 1'h0);
      check("flush", flush_cnt, fn[i]);
    end
    run(14'h0081, 1'h0, 1'h1);
    run(14'h0A86, 1'h0, 1'h0);
    run(14'h0063, 1'h0, 1'h0);
    run(14'h0000, 1'h0, 1'h0);
    check("slpto", watchdog_expiry_flag_o, 1'h1);
    check("slppd", sleep_entered_flag_o, 1'h0);
    run(14'h0064, 1'h0, 1'h0);
    run(14'h0000, 1'h0, 1'h0);
    check("clrpd", sleep_entered_flag_o, 1'h1);
    wdog_expired_i = 1'h1;
    run(14'h0000, 1'h0, 1'h0);
    run(14'h0000, 1'h0, 1'h0);
    check("wdto", watchdog_expiry_flag_o, 1'h0);
    wdog_expired_i = 1'h0;
    run(14'h0000, 1'h0, 1'h0);
    run(14'h0064, 1'h0, 1'h0);
    run(14'h0000, 1'h0, 1'h0);
    check("clrto", watchdog_expiry_flag_o, 1'h1);
    for (int i = 0; i < 200; i++) begin
      run(14'($random(seed)), 1'($random(seed)), 1'($random(seed)));
    end
    finish_test();
  end
endmodule : mcu_instruction_decoder_bench
